// File: common/timer0_pkg.sv
// Purpose : Shared constants and types for the timer with shared prescaler
// Assumes : APB, 32-bit data, one word per register index
// Notes   : Byte address of each register is four times its index
package timer0_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [9:0]  IDX_TIMER_COUNT   = 10'h001;  // Timer count
  localparam logic [9:0]  IDX_INT_CONTROL   = 10'h00B;  // Interrupt control
  localparam logic [9:0]  IDX_OPTION_CONFIG = 10'h081;  // Clock, assignment, ratio
  localparam logic [9:0]  IDX_PORT_A_DIR    = 10'h085;  // Port A direction
  localparam logic [9:0]  IDX_EVENT_STATUS  = 10'h090;  // Sticky events, write one clears
  localparam logic [9:0]  IDX_EVENT_MASK    = 10'h091;  // Event mask, same layout
  localparam logic [9:0]  IDX_WDT_CONTROL   = 10'h092;  // Watchdog enable
  localparam logic [9:0]  IDX_WDT_CLEAR     = 10'h093;  // Any write clears watchdog
  localparam int          ADDR_LSB          = 2;        // Word aligned

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_TIMER_COUNT   = 8'h00;
  localparam logic [7:0]  RST_INT_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_OPTION_CONFIG = 8'hFF;
  localparam logic [7:0]  RST_PORT_A_DIR    = 8'h3F;
  localparam logic [7:0]  PORT_A_DIR_MASK   = 8'h3F;   // Bits 7:6 unimplemented
  localparam logic [1:0]  RST_EVENTS        = 2'h0;

  // ==========================================================
  // Field positions
  localparam int          INTC_GLOBAL_EN    = 7;        // Global interrupt enable
  localparam int          INTC_OVF_EN       = 5;        // timer_overflow_enable
  localparam int          INTC_OVF_FLAG     = 2;        // timer_overflow_flag
  localparam int          EVT_OVERFLOW      = 0;        // Status bit: timer wrap
  localparam int          EVT_WDT_TIMEOUT   = 1;        // Status bit: watchdog expiry

  // ==========================================================
  // Timing
  localparam int          WDT_BASE_W        = 24;       // Watchdog base counter width
  localparam int          WDT_BASE_DEFAULT  = 1024;     // Cycles per unscaled watchdog tick

  // ==========================================================
  // Types
  typedef struct packed {
    logic       portPullupOff;            // Bit 7, stored only
    logic       extIntEdge;               // Bit 6, stored only
    logic       timer_clock_source_select; // Bit 5: 1 external pin
    logic       timer_edge_select;        // Bit 4: 1 falling edge
    logic       prescaler_assign_select;  // Bit 3: 1 watchdog owns prescaler
    logic [2:0] prescale_ratio_field;     // Bits 2:0
  } option_s;

  typedef struct packed {
    logic [7:0]            timerCount;    // timer_count
    logic [7:0]            intCtrl;       // interrupt_control
    option_s               option;        // timer_option_config
    logic [7:0]            portDir;       // port_a_direction
    logic [1:0]            evtStatus;     // Sticky events
    logic [1:0]            evtMask;       // Event mask
    logic                  wdtEnable;     // Watchdog running
    logic [7:0]            prescale;      // Shared prescaler contents
    logic [WDT_BASE_W-1:0] wdtBase;       // watchdog_counter base stage
    logic [2:0]            pinSync;       // External clock synchroniser
    logic                  pinStable;     // Filtered pin level
    logic                  wdtResetReq;   // Device reset request pulse
    logic                  irq;           // Interrupt level
    logic                  pready;        // APB ready
    logic                  pslverr;       // APB error
    logic [31:0]           prdata;        // APB read data
  } state_s;

endpackage : timer0_pkg

// File: hdl/timer0_wdt_prescaler_assign.sv
// Purpose : 8-bit timer sharing one prescaler with the watchdog, APB slave
// Assumes : clk_sys 100 MHz, synchronous active-high reset, ce freezes state
// Function
// - Prescaler owner changes by plain register write
// - Timer count write clears timer-owned prescaler
// - Watchdog clear also clears watchdog-owned prescaler
// - Assign bit set gives prescaler to watchdog
// - Assign bit clear gives prescaler to timer
// - Config holds source, assignment and ratio fields
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module timer0_wdt_prescaler_assign #(
  parameter int WDT_BASE_CYCLES = timer0_pkg::WDT_BASE_DEFAULT  // Shorten in simulation
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        timerClkPin,
  output logic             irq,
  output logic             wdtResetReq,
  output logic [7:0]       portADirection
);

  // ==========================================================
  // State and decode
  timer0_pkg::state_s st;        // Registered state
  timer0_pkg::state_s next_st;   // Next state

  logic [9:0]  idx;              // Register index
  logic        wrTake;           // Write completes this edge
  logic        rdSetup;          // Read setup cycle
  logic        extTick;          // Qualified pin edge
  logic        srcTick;          // Input to the prescaler
  logic        wdtBaseTick;      // Unscaled watchdog tick
  logic        presTick;         // Prescaler output
  logic        timerInc;         // Timer advances
  logic        wdtTimeout;       // Watchdog expiry
  logic        wdtClear;         // watchdog_clear_instruction
  logic        tmrWrite;         // Write to timer_count
  logic [3:0]  shamt;            // Ratio exponent
  logic [7:0]  presMask;         // Prescaler bits that must be all ones
  logic        mapped;           // Address hits a register
  logic [7:0]  rdByte;           // Read mux result

  // Watchdog base stage wraps after WDT_BASE_CYCLES cycles
  localparam int WDT_BASE_W_L = timer0_pkg::WDT_BASE_W;
  localparam logic [WDT_BASE_W_L-1:0] WDT_LAST = WDT_BASE_W_L'(WDT_BASE_CYCLES - 1);

  // ==========================================================
  // Bus decode; writes act only at the access edge with pready
  // Reads are captured in setup, so the access edge needs no mux
  always_comb begin
    idx     = paddr[11:timer0_pkg::ADDR_LSB];
    wrTake  = psel && penable && st.pready && pwrite;
    rdSetup = psel && !penable && !pwrite;
    tmrWrite = wrTake && (idx == timer0_pkg::IDX_TIMER_COUNT);
    wdtClear = wrTake && (idx == timer0_pkg::IDX_WDT_CLEAR);
    mapped  = (idx == timer0_pkg::IDX_TIMER_COUNT) || (idx == timer0_pkg::IDX_INT_CONTROL) ||
              (idx == timer0_pkg::IDX_OPTION_CONFIG) || (idx == timer0_pkg::IDX_PORT_A_DIR) ||
              (idx == timer0_pkg::IDX_EVENT_STATUS) || (idx == timer0_pkg::IDX_EVENT_MASK) ||
              (idx == timer0_pkg::IDX_WDT_CONTROL) || (idx == timer0_pkg::IDX_WDT_CLEAR);
  end

  // ==========================================================
  // Read mux; the clear register reads as zero
  always_comb begin
    case (idx)
      timer0_pkg::IDX_TIMER_COUNT:   rdByte = st.timerCount;
      timer0_pkg::IDX_INT_CONTROL:   rdByte = st.intCtrl;
      timer0_pkg::IDX_OPTION_CONFIG: rdByte = st.option;
      timer0_pkg::IDX_PORT_A_DIR:    rdByte = st.portDir;
      timer0_pkg::IDX_EVENT_STATUS:  rdByte = {6'h00, st.evtStatus};
      timer0_pkg::IDX_EVENT_MASK:    rdByte = {6'h00, st.evtMask};
      timer0_pkg::IDX_WDT_CONTROL:   rdByte = {7'h00, st.wdtEnable};
      default:                       rdByte = 8'h00;
    endcase
  end

  // ==========================================================
  // Tick sources and shared prescaler
  // Timer owner never gets 1:1, which keeps a write-clear visible
  always_comb begin
    // Pin edge, counted only once the two later stages agree
    extTick = (st.pinSync[1] == st.pinSync[2]) && (st.pinSync[2] != st.pinStable) &&
              (st.pinSync[2] == !st.option.timer_edge_select);
    wdtBaseTick = st.wdtBase == WDT_LAST;
    // Source is instruction clock or qualified pin
    if (st.option.timer_clock_source_select) begin
      srcTick = extTick;
    end else begin
      srcTick = 1'b1;
    end
    // Watchdog gets ratios from 1:1, timer from 1:2
    if (st.option.prescaler_assign_select) begin
      shamt = {1'b0, st.option.prescale_ratio_field};
    end else begin
      shamt = {1'b0, st.option.prescale_ratio_field} + 4'h1;
    end
    presMask = 8'((9'h001 << shamt) - 9'h001);
    if (st.option.prescaler_assign_select) begin
      // Owner follows the bit at once, no stop needed
      presTick   = wdtBaseTick && ((st.prescale & presMask) == presMask);
      timerInc   = srcTick;
      wdtTimeout = st.wdtEnable && presTick;
    end else begin
      presTick   = srcTick && ((st.prescale & presMask) == presMask);
      timerInc   = presTick;
      wdtTimeout = st.wdtEnable && wdtBaseTick;
    end
  end

  // ==========================================================
  // Next-state logic
  // Later assignments win, which sets the priority of events
  always_comb begin
    next_st = st;
    // Pin synchroniser; first stage read by the second only
    next_st.pinSync = {st.pinSync[1:0], timerClkPin};
    if (st.pinSync[1] == st.pinSync[2]) begin
      next_st.pinStable = st.pinSync[2];
    end
    // Prescaler counts its owner's source
    if ((st.option.prescaler_assign_select && wdtBaseTick) ||
        (!st.option.prescaler_assign_select && srcTick)) begin
      next_st.prescale = st.prescale + 8'h01;
    end
    // Watchdog base stage free runs
    next_st.wdtBase = wdtBaseTick ? '0 : st.wdtBase + 1'b1;
    // Timer increment and wrap
    if (timerInc) begin
      next_st.timerCount = st.timerCount + 8'h01;
    end
    // Watchdog request pulse; no write below touches it
    next_st.wdtResetReq = wdtTimeout;
    // Bus writes
    if (wrTake) begin
      case (idx)
        timer0_pkg::IDX_TIMER_COUNT: begin
          next_st.timerCount = pwdata[7:0];
          if (!st.option.prescaler_assign_select) begin
            next_st.prescale = 8'h00;
          end
        end
        timer0_pkg::IDX_INT_CONTROL:   next_st.intCtrl = pwdata[7:0];
        timer0_pkg::IDX_OPTION_CONFIG: next_st.option = pwdata[7:0];
        timer0_pkg::IDX_PORT_A_DIR:    next_st.portDir = pwdata[7:0] & timer0_pkg::PORT_A_DIR_MASK;
        timer0_pkg::IDX_EVENT_STATUS:  next_st.evtStatus = st.evtStatus & ~pwdata[1:0];
        timer0_pkg::IDX_EVENT_MASK:    next_st.evtMask = pwdata[1:0];
        timer0_pkg::IDX_WDT_CONTROL:   next_st.wdtEnable = pwdata[0];
        timer0_pkg::IDX_WDT_CLEAR: begin
          next_st.wdtBase = '0;
          if (st.option.prescaler_assign_select) begin
            next_st.prescale = 8'h00;
          end
        end
        default: begin
        end
      endcase
    end
    // Wrap flags raised after the write so a same-edge clear loses
    if (timerInc && !tmrWrite && (st.timerCount == 8'hFF)) begin
      next_st.intCtrl[timer0_pkg::INTC_OVF_FLAG] = 1'b1;
      next_st.evtStatus[timer0_pkg::EVT_OVERFLOW] = 1'b1;
    end
    if (wdtTimeout) begin
      next_st.evtStatus[timer0_pkg::EVT_WDT_TIMEOUT] = 1'b1;
      next_st.wdtBase = '0;
    end
    // Interrupt level from the values about to be stored
    next_st.irq = (|(next_st.evtStatus & next_st.evtMask)) ||
                  (next_st.intCtrl[timer0_pkg::INTC_GLOBAL_EN] &&
                   next_st.intCtrl[timer0_pkg::INTC_OVF_EN] &&
                   next_st.intCtrl[timer0_pkg::INTC_OVF_FLAG]);
    // APB answer prepared in setup, so no wait states
    next_st.pready  = psel && !penable;
    next_st.pslverr = psel && !penable && !mapped;
    if (rdSetup) begin
      next_st.prdata = {24'h000000, rdByte};
    end
  end

  // ==========================================================
  // State register; ce low freezes everything
  // Reset ignores ce so a frozen block can still be reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st           <= '0;
      st.timerCount <= timer0_pkg::RST_TIMER_COUNT;
      st.intCtrl   <= timer0_pkg::RST_INT_CONTROL;
      st.option    <= timer0_pkg::RST_OPTION_CONFIG;
      st.portDir   <= timer0_pkg::RST_PORT_A_DIR;
      st.evtStatus <= timer0_pkg::RST_EVENTS;
      st.evtMask   <= timer0_pkg::RST_EVENTS;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  // No logic between the state flops and the pins
  always_comb begin
    pready         = st.pready;
    prdata         = st.prdata;
    pslverr        = st.pslverr;
    irq            = st.irq;
    wdtResetReq    = st.wdtResetReq;
    portADirection = st.portDir;
  end

  // ==========================================================
  // Assertions
  // Bus-driven antecedents carry ce, since ce low holds every flop
  property p_option_write;
    @(posedge clk_sys) disable iff (reset)
      (ce && wrTake && idx == timer0_pkg::IDX_OPTION_CONFIG) |=> st.option == $past(pwdata[7:0]);
  endproperty
  a_option_write: assert property (p_option_write) else $error("option write lost");

  // Timer-owned prescaler restarts on a count write
  property p_tmr_write_clears;
    @(posedge clk_sys) disable iff (reset)
      (ce && tmrWrite && !st.option.prescaler_assign_select) |=> st.prescale == 8'h00;
  endproperty
  a_tmr_write_clears: assert property (p_tmr_write_clears) else $error("prescaler not cleared");

  // Watchdog clear restarts base stage and its prescaler
  property p_wdt_clear;
    @(posedge clk_sys) disable iff (reset)
      (ce && wdtClear && st.option.prescaler_assign_select) |=> (st.prescale == 8'h00 && st.wdtBase == '0);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear incomplete");

  property p_wdt_owner_direct;
    @(posedge clk_sys) disable iff (reset)
      (ce && st.option.prescaler_assign_select && srcTick && !tmrWrite)
        |=> st.timerCount == $past(st.timerCount) + 8'h01;
  endproperty
  a_wdt_owner_direct: assert property (p_wdt_owner_direct) else $error("timer not direct");

  property p_timer_owner_scaled;
    @(posedge clk_sys) disable iff (reset)
      (ce && !st.option.prescaler_assign_select && !presTick && !tmrWrite)
        |=> $stable(st.timerCount);
  endproperty
  a_timer_owner_scaled: assert property (p_timer_owner_scaled) else $error("timer ran unscaled");

  property p_option_read;
    @(posedge clk_sys) disable iff (reset)
      (ce && rdSetup && idx == timer0_pkg::IDX_OPTION_CONFIG)
        |=> (pready && prdata == {24'h000000, $past(st.option)});
  endproperty
  a_option_read: assert property (p_option_read) else $error("option readback wrong");

  // Wrap sets both flags whatever the enables say
  property p_overflow_irq;
    @(posedge clk_sys) disable iff (reset)
      (ce && timerInc && !tmrWrite && st.timerCount == 8'hFF)
        |=> (st.timerCount == 8'h00 && st.intCtrl[timer0_pkg::INTC_OVF_FLAG] &&
             st.evtStatus[timer0_pkg::EVT_OVERFLOW]);
  endproperty
  a_overflow_irq: assert property (p_overflow_irq) else $error("overflow flag missing");

  // Interrupt level tracks pending enabled events in the same cycle
  property p_irq_level;
    @(posedge clk_sys) disable iff (reset)
      irq == ((|(st.evtStatus & st.evtMask)) ||
              (st.intCtrl[timer0_pkg::INTC_GLOBAL_EN] && st.intCtrl[timer0_pkg::INTC_OVF_EN] &&
               st.intCtrl[timer0_pkg::INTC_OVF_FLAG]));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  // A timer count write loads the written byte
  property p_tmr_load;
    @(posedge clk_sys) disable iff (reset)
      (ce && tmrWrite) |=> st.timerCount == $past(pwdata[7:0]);
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("timer load lost");

  // ce low holds the counters, bus answer included
  property p_ce_freeze;
    @(posedge clk_sys) disable iff (reset)
      !ce |=> ($stable(st.timerCount) && $stable(st.prescale) && $stable(pready));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

  c_overflow: cover property (@(posedge clk_sys) disable iff (reset) st.intCtrl[2] && irq);
  c_wdt_timeout: cover property (@(posedge clk_sys) disable iff (reset) wdtResetReq);
  c_switch: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(st.option.prescaler_assign_select));
  c_irq_ctrl: cover property (@(posedge clk_sys) disable iff (reset)
    st.intCtrl[timer0_pkg::INTC_GLOBAL_EN] && st.intCtrl[timer0_pkg::INTC_OVF_EN] && irq);
  c_ce_freeze: cover property (@(posedge clk_sys) disable iff (reset) !ce);

endmodule : timer0_wdt_prescaler_assign

// File: testbench/tb_top.sv
// Purpose : Register-level bench for the timer with shared prescaler
// Assumes : Zero-wait APB slave, WDT_BASE_CYCLES shortened to 8
// Notes   : Watchdog request pulses are counted by a monitor, not polled
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Stimulus and observation
  logic        clk_sys     = 1'b0;   // 100 MHz
  logic        reset       = 1'b1;   // Synchronous, active high
  logic        ce          = 1'b1;   // Low in one freeze scenario
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h00000000;
  logic        timerClkPin = 1'b0;   // External count source
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic        wdtResetReq;
  logic [7:0]  portADirection;
  int          err_total   = 0;      // Mismatches
  int          checked     = 0;      // Comparisons
  int          pulses      = 0;      // Watchdog requests seen
  int          waitCnt;              // Cycles until watchdog expiry
  logic [31:0] rdVal;                // Last read word
  logic        rdErr;                // Last error flag

  // Free-running clock
  always #5 clk_sys = ~clk_sys;

  timer0_wdt_prescaler_assign #(.WDT_BASE_CYCLES(8)) timer0_wdt_prescaler_assign_inst (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timerClkPin(timerClkPin), .irq(irq), .wdtResetReq(wdtResetReq), .portADirection(portADirection));

  // Monitor: request is a one-cycle pulse, so count per edge
  always @(posedge clk_sys) begin
    if (wdtResetReq === 1'b1) pulses++;
  end

  // ==========================================================
  // Tasks
  task test_done;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Single compare for all word-sized results
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    rdVal   = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task rd(input logic [9:0] idx, input logic [7:0] exp, input string msg);
    apb(1'b0, idx, 8'h00);
    chk(rdVal, {24'h000000, exp}, msg);
  endtask : rd

  // Interrupt output is registered, so let it settle first
  task irqIs(input logic exp);
    repeat (3) @(posedge clk_sys);
    chk({31'h00000000, irq}, {31'h00000000, exp}, "irq level");
  endtask : irqIs

  // Pin pulses wide enough for the three-flop synchroniser
  task pinPulses(input int n);
    repeat (n) begin
      @(posedge clk_sys) timerClkPin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      timerClkPin <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask : pinPulses

  // ==========================================================
  // Hang guard, well above the expected run length
  initial begin
    #900000;
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h00, "timer reset");
    rd(timer0_pkg::IDX_INT_CONTROL, 8'h00, "intctl reset");
    rd(timer0_pkg::IDX_OPTION_CONFIG, 8'hFF, "option reset");
    rd(timer0_pkg::IDX_PORT_A_DIR, 8'h3F, "portdir reset");
    apb(1'b0, 10'h3FF, 8'h00);
    chk({31'h00000000, rdErr}, 32'h00000001, "unmapped error");
    wr(timer0_pkg::IDX_PORT_A_DIR, 8'hFF);
    rd(timer0_pkg::IDX_PORT_A_DIR, 8'h3F, "portdir upper bits");
    chk({24'h000000, portADirection}, 32'h0000003F, "portdir pins");
    // Pin source, prescaler away from timer: every rising edge counts
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h28);
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    pinPulses(10);
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h0A, "rising pin count");
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h38);
    pinPulses(3);
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h0D, "falling pin count");
    // Wrap sets both flags; mask gates the output
    wr(timer0_pkg::IDX_EVENT_MASK, 8'h01);
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'hFE);
    pinPulses(2);
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h00, "wrap to zero");
    rd(timer0_pkg::IDX_EVENT_STATUS, 8'h01, "overflow event");
    rd(timer0_pkg::IDX_INT_CONTROL, 8'h04, "overflow flag");
    irqIs(1'b1);
    wr(timer0_pkg::IDX_EVENT_MASK, 8'h00);
    irqIs(1'b0);
    wr(timer0_pkg::IDX_EVENT_MASK, 8'h01);
    irqIs(1'b1);
    wr(timer0_pkg::IDX_EVENT_STATUS, 8'h01);
    irqIs(1'b0);
    wr(timer0_pkg::IDX_INT_CONTROL, 8'hA4);
    irqIs(1'b1);
    wr(timer0_pkg::IDX_INT_CONTROL, 8'h00);
    irqIs(1'b0);
    rd(timer0_pkg::IDX_INT_CONTROL, 8'h00, "flag cleared");
    wr(timer0_pkg::IDX_EVENT_MASK, 8'h00);
    // Timer owns prescaler at 1:256; count write restarts it
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h07);
    repeat (300) @(posedge clk_sys);
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h10);
    repeat (236) @(posedge clk_sys);
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h10, "prescaler cleared");
    repeat (30) @(posedge clk_sys);
    rd(timer0_pkg::IDX_TIMER_COUNT, 8'h11, "first tick at 256");
    // Hand prescaler to watchdog on the fly, ratio kept
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h0F);
    rd(timer0_pkg::IDX_OPTION_CONFIG, 8'h0F, "owner watchdog");
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    apb(1'b0, timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    chk({31'h00000000, rdVal[7:0] >= 8'h01 && rdVal[7:0] <= 8'h04}, 32'h00000001, "timer unscaled");
    // Watchdog at 8 x 4 cycles; frequent clears hold it off
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h0A);
    wr(timer0_pkg::IDX_WDT_CLEAR, 8'h00);
    wr(timer0_pkg::IDX_WDT_CONTROL, 8'h01);
    repeat (30) wr(timer0_pkg::IDX_WDT_CLEAR, 8'h00);
    chk(pulses, 32'h00000000, "no expiry while cleared");
    waitCnt = 0;
    while (pulses == 0 && waitCnt < 500) begin
      @(posedge clk_sys);
      waitCnt++;
    end
    chk({31'h00000000, waitCnt >= 26 && waitCnt <= 48}, 32'h00000001, "full period after clear");
    wr(timer0_pkg::IDX_WDT_CONTROL, 8'h00);
    apb(1'b0, timer0_pkg::IDX_EVENT_STATUS, 8'h00);
    chk(rdVal & 32'h00000002, 32'h00000002, "timeout event");
    wr(timer0_pkg::IDX_EVENT_MASK, 8'h02);
    irqIs(1'b1);
    wr(timer0_pkg::IDX_EVENT_STATUS, 8'h02);
    irqIs(1'b0);
    waitCnt = pulses;
    repeat (200) @(posedge clk_sys);
    chk(pulses, waitCnt, "disabled watchdog silent");
    // Watchdog back to timer: clear first, then owner and ratio
    wr(timer0_pkg::IDX_WDT_CLEAR, 8'h00);
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h01);
    rd(timer0_pkg::IDX_OPTION_CONFIG, 8'h01, "owner timer");
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    repeat (10) @(posedge clk_sys);
    apb(1'b0, timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    chk({31'h00000000, rdVal[7:0] >= 8'h02 && rdVal[7:0] <= 8'h04}, 32'h00000001, "timer by four");
    // ce low freezes timer and prescaler; eleven running edges give 2
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    ce <= 1'b0;
    repeat (50) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    chk(rdVal, 32'h00000002, "frozen by ce");
    // Timer to watchdog with 1:1 final: temporary ratio already set
    wr(timer0_pkg::IDX_TIMER_COUNT, 8'h00);
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h09);
    wr(timer0_pkg::IDX_WDT_CLEAR, 8'h00);
    wr(timer0_pkg::IDX_OPTION_CONFIG, 8'h08);
    rd(timer0_pkg::IDX_OPTION_CONFIG, 8'h08, "final one to one");
    chk(pulses, waitCnt, "no reset on switch");
    test_done();
  end
endmodule : tb_top
